// ### src/adg_pkg.sv
// Package for the acquisition diagnostic and switch check block
package adg_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_DIAG_CONFIG  = 6'h00;
  localparam logic [5:0] OFS_SCAN_CONTROL = 6'h04;
  localparam logic [5:0] OFS_DIAG_RESULT_A = 6'h08;
  localparam logic [5:0] OFS_DIAG_RESULT_B = 6'h0c;
  localparam logic [5:0] OFS_SW_THRESH    = 6'h10;
  localparam logic [5:0] OFS_SW_HIGH      = 6'h14;
  localparam logic [5:0] OFS_CELL_CFG     = 6'h18;
  localparam logic [5:0] OFS_ALERT        = 6'h1c;
  localparam logic [5:0] OFS_PASS         = 6'h20;
  localparam logic [5:0] OFS_OVERRIDE     = 6'h24;
  // Field positions in scan_control_reg
  localparam int SC_START    = 0;
  localparam int SC_SHAPE    = 1;
  localparam int SC_STUCK_EN = 2;
  localparam int SC_CFG_LO   = 4;
  localparam int SC_OVS_LO   = 8;
  localparam int SC_TOPA_LO  = 12;
  localparam int SC_TOPB_LO  = 16;
  // Alert register fields
  localparam int AL_SUM      = 16;
  localparam int AL_DONE     = 17;
  localparam int AL_OV       = 18;
  localparam int AL_UV       = 19;
  localparam int AL_MM       = 20;
  // Diagnostic select codes
  localparam logic [3:0] DG_NONE   = 4'h0;
  localparam logic [3:0] DG_OFFSET = 4'h6;
  localparam logic [3:0] DG_DAC_HI = 4'h7;
  localparam logic [3:0] DG_DAC_LO = 4'h8;
  localparam logic [3:0] DG_THERM  = 4'h9;
  localparam logic [3:0] DG_ZERO   = 4'ha;
  localparam logic [3:0] DG_FULL   = 4'hb;
  localparam logic [3:0] DG_LEVEL_SHIFT_AMP  = 4'hc;
  // Scan configuration codes
  localparam logic [2:0] SCF_SHORT = 3'h4;
  localparam logic [2:0] SCF_OPEN  = 3'h5;
  localparam logic [2:0] SCF_ODD   = 3'h6;
  localparam logic [2:0] SCF_EVEN  = 3'h7;
  // Pass windows, 14-bit results
  localparam logic [13:0] OFS_PYR_LO = 14'h1ff6;
  localparam logic [13:0] OFS_PYR_HI = 14'h200a;
  localparam logic [13:0] OFS_RMP_LO = 14'h1fea;
  localparam logic [13:0] OFS_RMP_HI = 14'h2011;
  localparam logic [13:0] THM_LO     = 14'h1f91;
  localparam logic [13:0] THM_HI     = 14'h2070;
  localparam logic [13:0] MID_SCALE  = 14'h2000;
  localparam logic [13:0] LSA_LO     = 14'h1fd4;
  localparam logic [13:0] LSA_HI     = 14'h202d;
  localparam logic [13:0] ZERO_CODE  = 14'h0000;
  localparam logic [13:0] FULL_CODE  = 14'h3fff;
  localparam logic [13:0] DLO_LO     = 14'h0f4d;
  localparam logic [13:0] DLO_HI     = 14'h1086;
  localparam logic [13:0] DHI_LO     = 14'h2f06;
  localparam logic [13:0] DHI_HI     = 14'h30a4;
  localparam logic [11:0] DAC_QUARTER = 12'h3ff;
  localparam logic [11:0] DAC_3QUART  = 12'hc00;
  localparam logic [13:0] ODD_SW     = 14'h1555;
  localparam logic [13:0] EVEN_SW    = 14'h2aaa;
  localparam logic [2:0]  OVS_MIN16  = 3'h3;
  localparam int          NCH        = 14;
  // Analog path override bundle
  typedef struct packed {
    logic        adc_in_short;
    logic        amp_in_short;
    logic        level_shift_amp_short;
    logic        therm_ref;
    logic        to_neg_supply;
    logic        to_pos_supply;
    logic        dac_route;
    logic [11:0] dac_code;
    logic        force_bipolar;
    logic        no_chop;
    logic        alternate_mux_path;
    logic        stuck_check;
    logic        ovs_force_one;
  } adg_ovr_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_EVAL = 2'b10
  } adg_state_t;
endpackage

// ### src/adg_diag.sv
// Diagnostic selection, evaluation and switch check logic
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - Offset code 0110 runs offset check to result
// - Shape 0 shorts converter, 1 shorts amplifier
// - Pyramid offset passes 1ff6 to 200a
// - Ramp offset passes 1fea to 2011
// - Code 1001 shorts converter, thermistor reference
// - Thermistor offset passes 1f91 to 2070
// - Code 1100 shorts shift amp, no chop
// - Shift amp offset passes 1fd4 to 202d
// - Code 1010 drives negative supply, expects zero
// - Code 1011 drives positive supply, expects 3fff
// - Stuck check enable appends end-of-scan check
// - Quarter-scale loads 3ff, passes 0f4d-1086
// - Three-quarter loads c00, passes 2f06-30a4
// - Scan config codes select four switch checks
// - Switch modes override settings, alternate mux
// - Compare each channel against its mode threshold
// - Alert vector cleared on request, written end
// - Short below threshold; others outside window
// - Summary is OR of vector; write zero clears
// - Equal top cells mask channels above top
// - Switch modes leave cell alerts unchanged
// - Short mode disables switches, measures unipolar
module adg_diag
  import adg_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             acq_start,
  input  wire logic        acq_done,
  input  wire logic        acq_sample_valid,
  input  wire logic [3:0]  acq_sample_chan,
  input  wire logic        acq_sample_diag_b,
  input  wire logic [13:0] acq_sample_data,
  input  wire logic        acq_cell_alert_valid,
  input  wire logic [2:0]  acq_cell_alert,
  output adg_ovr_t         path_override,
  output logic [13:0]      balance_switch_enable,
  output logic [13:0]      channel_measure_enable
);
  logic [31:0] diag_config_reg_ff;
  logic [31:0] scan_control_reg_ff;
  logic [31:0] thr_ff;
  logic [31:0] thr_high_ff;
  logic [31:0] cell_cfg_ff;
  logic [15:0] diag_result_a_ff;
  logic [15:0] diag_result_b_ff;
  logic [13:0] switch_alert_vector_ff;
  logic [13:0] sw_pending_ff;
  logic        switch_alert_summary_ff;
  logic        scan_complete_flag_ff;
  logic [2:0]  cell_alert_ff;
  logic [1:0]  pass_ff;
  logic        rd_ack_ff;
  logic        start_ff;
  adg_state_t  state_ff;

  logic [3:0]  diag_select_a;
  logic [3:0]  diag_select_b;
  logic [13:0] switch_short_threshold;
  logic [13:0] switch_low_threshold;
  logic [13:0] switch_high_threshold;
  logic [13:0] sw_enable_cfg;
  logic [13:0] channel_bipolar_flag;
  logic [13:0] cell_en_cfg;
  logic        scan_shape_select;
  logic [2:0]  scan_config_field;
  logic [2:0]  oversample_count;
  logic [3:0]  top_cell_a;
  logic [3:0]  top_cell_b;
  logic        sw_mode;
  logic        end_scan_stuck_check_en;
  logic [13:0] top_mask;
  logic [13:0] ch_fault;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] wmask;
  logic [31:0] rd_mux;

  assign diag_select_a          = diag_config_reg_ff[3:0];
  assign diag_select_b          = diag_config_reg_ff[7:4];
  assign scan_shape_select      = scan_control_reg_ff[SC_SHAPE];
  assign end_scan_stuck_check_en = scan_control_reg_ff[SC_STUCK_EN];
  assign scan_config_field      = scan_control_reg_ff[SC_CFG_LO +: 3];
  assign oversample_count       = scan_control_reg_ff[SC_OVS_LO +: 3];
  assign top_cell_a             = scan_control_reg_ff[SC_TOPA_LO +: 4];
  assign top_cell_b             = scan_control_reg_ff[SC_TOPB_LO +: 4];
  assign switch_short_threshold = thr_ff[13:0];
  assign switch_low_threshold   = thr_ff[29:16];
  assign switch_high_threshold  = thr_high_ff[13:0];
  assign sw_enable_cfg          = cell_cfg_ff[13:0];
  assign channel_bipolar_flag   = cell_cfg_ff[29:16];
  assign cell_en_cfg            = diag_config_reg_ff[29:16];
  assign sw_mode                = scan_config_field[2];

  // Bus: writes finish in one cycle, reads take one wait state
  assign wr_acc          = avs_write;
  assign rd_acc          = avs_read && rd_ack_ff;
  assign avs_waitrequest = avs_read && !rd_ack_ff;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_ack_ff <= 1'b0;
    end else begin
      rd_ack_ff <= avs_read && !rd_ack_ff;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] mask,
                                        input logic [31:0] val);
    merge = (old & ~mask) | (val & mask);
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_config_reg_ff <= 32'h0000_0000;
      thr_ff             <= 32'h0000_0000;
      thr_high_ff        <= 32'h0000_0000;
      cell_cfg_ff        <= 32'h0000_0000;
    end else if (wr_acc) begin
      case (avs_address)
        OFS_DIAG_CONFIG:
          diag_config_reg_ff <= merge(diag_config_reg_ff, wmask,
                                      avs_writedata);
        OFS_SW_THRESH:
          thr_ff <= merge(thr_ff, wmask, avs_writedata);
        OFS_SW_HIGH:
          thr_high_ff <= merge(thr_high_ff, wmask, avs_writedata);
        OFS_CELL_CFG:
          cell_cfg_ff <= merge(cell_cfg_ff, wmask, avs_writedata);
        default: ;
      endcase
    end
  end

  // Start bit is self-clearing and is never stored
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_control_reg_ff <= 32'h0000_0000;
      start_ff            <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (wr_acc && avs_address == OFS_SCAN_CONTROL) begin
        scan_control_reg_ff <= merge(scan_control_reg_ff, wmask,
                                     avs_writedata) & ~32'h0000_0001;
        start_ff <= avs_byteenable[0] && avs_writedata[SC_START] &&
                    state_ff == ST_IDLE;
      end
    end
  end
  assign acq_start = start_ff;

  // Scan sequencing
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: state_ff <= start_ff ? ST_RUN : ST_IDLE;
        ST_RUN:  state_ff <= acq_done ? ST_EVAL : ST_RUN;
        ST_EVAL: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Analog overrides for the active diagnostic or switch mode
  always_comb begin
    logic [3:0] d;
    d = (diag_select_a != DG_NONE) ? diag_select_a : diag_select_b;
    path_override = '0;
    path_override.stuck_check = end_scan_stuck_check_en;
    if (sw_mode) begin
      path_override.alternate_mux_path = 1'b1;
      path_override.ovs_force_one      = 1'b1;
      path_override.force_bipolar      = scan_config_field != SCF_SHORT;
    end else begin
      case (d)
        DG_OFFSET: begin
          path_override.adc_in_short  = !scan_shape_select;
          path_override.amp_in_short  = scan_shape_select;
          path_override.no_chop       = scan_shape_select;
          path_override.force_bipolar = 1'b1;
        end
        DG_THERM: begin
          path_override.adc_in_short  = 1'b1;
          path_override.therm_ref     = 1'b1;
          path_override.force_bipolar = 1'b1;
        end
        DG_LEVEL_SHIFT_AMP: begin
          path_override.level_shift_amp_short   = 1'b1;
          path_override.no_chop       = 1'b1;
          path_override.force_bipolar = 1'b1;
        end
        DG_ZERO: begin
          path_override.to_neg_supply = 1'b1;
          path_override.force_bipolar = 1'b1;
        end
        DG_FULL: begin
          path_override.to_pos_supply = 1'b1;
          path_override.force_bipolar = 1'b1;
        end
        DG_DAC_LO: begin
          path_override.dac_route = 1'b1;
          path_override.dac_code  = DAC_QUARTER;
        end
        DG_DAC_HI: begin
          path_override.dac_route = 1'b1;
          path_override.dac_code  = DAC_3QUART;
        end
        default: ;
      endcase
    end
  end

  // Switch and measurement enables per mode
  always_comb begin
    balance_switch_enable  = sw_enable_cfg;
    channel_measure_enable = cell_en_cfg;
    case (scan_config_field)
      SCF_SHORT: begin
        balance_switch_enable  = '0;
        channel_measure_enable = cell_en_cfg & ~channel_bipolar_flag;
      end
      SCF_OPEN: begin
        channel_measure_enable = sw_enable_cfg & ~channel_bipolar_flag;
      end
      SCF_ODD, SCF_EVEN: begin
        balance_switch_enable = (scan_config_field == SCF_ODD ? ODD_SW :
                                 EVEN_SW) & ~channel_bipolar_flag &
                                top_mask;
        channel_measure_enable = balance_switch_enable;
      end
      default: ;
    endcase
  end

  // Channels above the top cell are masked only when tops agree
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      assign top_mask[gi] = (top_cell_a != top_cell_b) ||
                            (4'(gi) <= top_cell_a);
      assign ch_fault[gi] = acq_sample_valid && sw_mode &&
        acq_sample_chan == 4'(gi) && channel_measure_enable[gi] &&
        top_mask[gi] &&
        ((scan_config_field == SCF_SHORT) ?
          (acq_sample_data < switch_short_threshold) :
          (acq_sample_data < switch_low_threshold ||
           acq_sample_data > switch_high_threshold));
    end
  endgenerate

  function automatic logic in_win(input logic [13:0] v,
                                  input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_win = v >= lo && v <= hi;
  endfunction

  function automatic logic judge(input logic [3:0] d,
                                 input logic shape,
                                 input logic [13:0] v);
    case (d)
      DG_OFFSET: judge = shape ? in_win(v, OFS_RMP_LO, OFS_RMP_HI)
                               : in_win(v, OFS_PYR_LO, OFS_PYR_HI);
      DG_THERM:  judge = in_win(v, THM_LO, THM_HI);
      DG_LEVEL_SHIFT_AMP:  judge = in_win(v, LSA_LO, LSA_HI);
      DG_ZERO:   judge = v == ZERO_CODE;
      DG_FULL:   judge = v == FULL_CODE;
      DG_DAC_LO: judge = in_win(v, DLO_LO, DLO_HI);
      DG_DAC_HI: judge = in_win(v, DHI_LO, DHI_HI);
      default:   judge = 1'b0;
    endcase
  endfunction

  // Diagnostic results, left aligned in 16 bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_result_a_ff <= 16'h0000;
      diag_result_b_ff <= 16'h0000;
      pass_ff          <= 2'b00;
    end else if (acq_sample_valid && state_ff == ST_RUN && !sw_mode) begin
      if (!acq_sample_diag_b) begin
        diag_result_a_ff <= {acq_sample_data, 2'b00};
        pass_ff[0] <= judge(diag_select_a, scan_shape_select,
                            acq_sample_data);
      end else begin
        diag_result_b_ff <= {acq_sample_data, 2'b00};
        pass_ff[1] <= judge(diag_select_b, scan_shape_select,
                            acq_sample_data);
      end
    end
  end

  // Switch alert collection and publication
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_pending_ff          <= '0;
      switch_alert_vector_ff <= '0;
      switch_alert_summary_ff <= 1'b0;
    end else begin
      if (start_ff && sw_mode) begin
        sw_pending_ff          <= '0;
        switch_alert_vector_ff <= '0;
      end else if (state_ff == ST_RUN) begin
        sw_pending_ff <= sw_pending_ff | ch_fault;
      end
      if (state_ff == ST_EVAL && sw_mode) begin
        switch_alert_vector_ff  <= sw_pending_ff & top_mask;
        switch_alert_summary_ff <= |(sw_pending_ff & top_mask);
      end else if (wr_acc && avs_address == OFS_ALERT &&
                   avs_byteenable[2] && !avs_writedata[AL_SUM]) begin
        switch_alert_summary_ff <= 1'b0;
      end
    end
  end

  // Scan-complete flag; a new completion wins over a clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_complete_flag_ff <= 1'b0;
    end else if (state_ff == ST_EVAL) begin
      scan_complete_flag_ff <= 1'b1;
    end else if (start_ff) begin
      scan_complete_flag_ff <= 1'b0;
    end
  end

  // Cell alerts follow only normal measurement scans
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_alert_ff <= 3'b000;
    end else if (acq_cell_alert_valid && !sw_mode) begin
      cell_alert_ff <= acq_cell_alert;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      OFS_DIAG_CONFIG:   rd_mux = diag_config_reg_ff;
      OFS_SCAN_CONTROL:  rd_mux = scan_control_reg_ff;
      OFS_DIAG_RESULT_A: rd_mux = {16'h0000, diag_result_a_ff};
      OFS_DIAG_RESULT_B: rd_mux = {16'h0000, diag_result_b_ff};
      OFS_SW_THRESH:     rd_mux = thr_ff;
      OFS_SW_HIGH:       rd_mux = thr_high_ff;
      OFS_CELL_CFG:      rd_mux = cell_cfg_ff;
      OFS_ALERT:         rd_mux = {11'h000, cell_alert_ff,
                                   scan_complete_flag_ff,
                                   switch_alert_summary_ff, 2'b00,
                                   switch_alert_vector_ff};
      OFS_PASS:          rd_mux = {28'h0000000, state_ff != ST_IDLE,
                                   oversample_count >= OVS_MIN16,
                                   pass_ff};
      OFS_OVERRIDE:      rd_mux = {8'h00, path_override};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_ack_ff) begin
      avs_readdata <= rd_mux;
    end
  end
endmodule

// ### bench/adg_diag_sva.sv
// Assertions on the ports of the diagnostic block
`timescale 1ns/10ps
module adg_diag_sva
  import adg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        acq_start,
  input wire adg_ovr_t    path_override
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  wr_no_wait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  rd_first_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered in its first cycle");
  rd_answer_a: assert property (avs_read && avs_waitrequest |=>
    !avs_waitrequest)
    else $error("read not answered one cycle later");
  start_cause_a: assert property (acq_start |->
    $past(avs_write && avs_address == OFS_SCAN_CONTROL &&
          avs_writedata[SC_START]))
    else $error("start without a start write");
  start_pulse_a: assert property (acq_start |=> !acq_start)
    else $error("start longer than one cycle");
  conv_short_a: assert property (path_override.adc_in_short |->
    path_override.force_bipolar)
    else $error("shorted converter not bipolar");
  amp_short_a: assert property (path_override.amp_in_short |->
    path_override.force_bipolar && path_override.no_chop)
    else $error("shorted amplifier chopped or unipolar");
  therm_ref_a: assert property (path_override.therm_ref |->
    path_override.adc_in_short && path_override.force_bipolar)
    else $error("reference check without short");
  shift_amp_a: assert property (path_override.level_shift_amp_short |->
    path_override.force_bipolar && path_override.no_chop)
    else $error("shift amp check chopped or unipolar");
  supply_in_a: assert property (path_override.to_neg_supply ||
    path_override.to_pos_supply |-> path_override.force_bipolar)
    else $error("supply check not bipolar");
  dac_code_a: assert property (path_override.dac_route |->
    path_override.dac_code == DAC_QUARTER ||
    path_override.dac_code == DAC_3QUART)
    else $error("wrong converter test code");
endmodule

// ### bench/adg_acq_model.sv
// Acquisition engine model answering scan starts
`timescale 1ns/10ps
module adg_acq_model
  import adg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        acq_start,
  input wire adg_ovr_t    path_override,
  input wire logic [13:0] channel_measure_enable,
  input wire logic [7:0]  gap,
  input wire logic        diag_b,
  input wire logic [13:0] diag_val,
  output logic            acq_done,
  output logic            acq_sample_valid,
  output logic [3:0]      acq_sample_chan,
  output logic            acq_sample_diag_b,
  output logic [13:0]     acq_sample_data,
  output logic            acq_cell_alert_valid,
  output logic [2:0]      acq_cell_alert
);
  int   q[$];
  logic alt;

  initial begin
    {acq_done, acq_sample_valid, acq_cell_alert_valid, acq_sample_chan,
     acq_sample_diag_b, acq_sample_data, acq_cell_alert} = '0;
    forever begin
      @(posedge ref_clk);
      if (reset_n === 1'b1 && acq_start === 1'b1) begin
        repeat (gap) @(posedge ref_clk);
        alt = path_override.alternate_mux_path;
        q = {};
        for (int i = 0; i < NCH; i++)
          if (alt ? channel_measure_enable[i] : i == 0) q.push_back(i);
        foreach (q[k]) begin
          acq_sample_valid <= 1'b1;
          acq_sample_chan <= 4'(q[k]);
          acq_sample_diag_b <= diag_b;
          acq_sample_data <= alt ? 14'(q[k] * 256) : diag_val;
          @(posedge ref_clk);
        end
        acq_sample_valid <= 1'b0;
        acq_sample_data <= ~acq_sample_data;
        acq_cell_alert_valid <= 1'b1;
        acq_cell_alert <= alt ? 3'h2 : 3'h5;
        acq_done <= 1'b1;
        @(posedge ref_clk);
        acq_cell_alert_valid <= 1'b0;
        acq_done <= 1'b0;
      end
    end
  end
endmodule

// ### bench/acquisition_diag_and_balsw_check_test.sv
// Self-checking bench for the diagnostic and switch check block
`timescale 1ns/10ps
module acquisition_diag_and_balsw_check_test
  import adg_pkg::*;
;
  typedef struct packed {
    logic [3:0]  sel;
    logic [2:0]  cfg;
    logic        shape;
    logic [3:0]  top_b;
    logic [13:0] d;
    logic        ok;
    logic [13:0] x;
  } adg_row_t;
  // Diag rows: x is {conv short, amp short, shift short, ref}
  // Switch rows: x is the expected alert vector
  adg_row_t rows [24] = '{
    '{4'h6,3'h0,1'h0,4'hd,14'h1ff5,1'h0,14'h8},
    '{4'h6,3'h0,1'h0,4'hd,14'h1ff6,1'h1,14'h8},
    '{4'h6,3'h0,1'h0,4'hd,14'h200a,1'h1,14'h8},
    '{4'h6,3'h0,1'h0,4'hd,14'h200b,1'h0,14'h8},
    '{4'h6,3'h0,1'h1,4'hd,14'h1fe9,1'h0,14'h4},
    '{4'h6,3'h0,1'h1,4'hd,14'h2011,1'h1,14'h4},
    '{4'h9,3'h0,1'h0,4'hd,14'h1f90,1'h0,14'h9},
    '{4'h9,3'h0,1'h0,4'hd,14'h2070,1'h1,14'h9},
    '{4'hc,3'h0,1'h0,4'hd,14'h1fd4,1'h1,14'h2},
    '{4'hc,3'h0,1'h0,4'hd,14'h202e,1'h0,14'h2},
    '{4'ha,3'h0,1'h0,4'hd,14'h0000,1'h1,14'h0},
    '{4'ha,3'h0,1'h0,4'hd,14'h0001,1'h0,14'h0},
    '{4'hb,3'h0,1'h0,4'hd,14'h3fff,1'h1,14'h0},
    '{4'hb,3'h0,1'h0,4'hd,14'h3ffe,1'h0,14'h0},
    '{4'h8,3'h0,1'h0,4'hd,14'h0f4d,1'h1,14'h0},
    '{4'h8,3'h0,1'h0,4'hd,14'h1087,1'h0,14'h0},
    '{4'h7,3'h0,1'h0,4'hd,14'h30a4,1'h1,14'h0},
    '{4'h7,3'h0,1'h0,4'hd,14'h2f05,1'h0,14'h0},
    '{4'h0,3'h4,1'h0,4'hd,14'h0,1'h0,14'h001e},
    '{4'h0,3'h5,1'h0,4'hd,14'h0,1'h0,14'h3806},
    '{4'h0,3'h5,1'h0,4'hc,14'h0,1'h0,14'h1806},
    '{4'h0,3'h6,1'h0,4'hd,14'h0,1'h0,14'h1004},
    '{4'h0,3'h7,1'h0,4'hd,14'h0,1'h0,14'h2802},
    '{4'h0,3'h7,1'h0,4'hc,14'h0,1'h0,14'h0802}};

  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        avs_waitrequest, acq_start, acq_done, acq_sample_valid;
  logic        acq_sample_diag_b, acq_cell_alert_valid, dg_b = 1'b0;
  logic [3:0]  acq_sample_chan;
  logic [13:0] acq_sample_data, balance_switch_enable;
  logic [13:0] channel_measure_enable, dval = 14'h0;
  logic [2:0]  acq_cell_alert;
  logic [7:0]  gap = 8'h01;
  adg_ovr_t    path_override;
  int          error_cnt = 0, num_checks = 0;

  always #4 ref_clk = ~ref_clk;

  adg_diag u_adg_diag (.*);

  adg_acq_model u_adg_acq_model (
    .ref_clk(ref_clk), .reset_n(reset_n), .acq_start(acq_start),
    .path_override(path_override),
    .channel_measure_enable(channel_measure_enable), .gap(gap),
    .diag_b(dg_b), .diag_val(dval), .acq_done(acq_done),
    .acq_sample_valid(acq_sample_valid),
    .acq_sample_chan(acq_sample_chan),
    .acq_sample_diag_b(acq_sample_diag_b),
    .acq_sample_data(acq_sample_data),
    .acq_cell_alert_valid(acq_cell_alert_valid),
    .acq_cell_alert(acq_cell_alert));

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One bus cycle; answer taken at the edge with waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      conclude();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic scan(input adg_row_t r, input logic b);
    dval = r.d;
    dg_b = b;
    bus(1'b1, OFS_DIAG_CONFIG, {2'h0, 14'h3fff, 8'h0, b ? r.sel : 4'h0,
        b ? 4'h0 : r.sel}, 4'hf, q);
    bus(1'b1, OFS_SCAN_CONTROL, {12'h0, r.top_b, 4'hc, 1'h0, 3'h3, 1'h0,
        r.cfg, 2'h0, r.shape, 1'h1}, 4'hf, q);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (acq_done !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (acq_done !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    repeat (3) @(posedge ref_clk);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1'b0, OFS_ALERT, 32'h0, 4'hf, q);
    chk("alert reset", 32'h0, q);
    bus(1'b0, 6'h30, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_SW_THRESH, 32'h0300_0500, 4'hf, q);
    bus(1'b1, OFS_SW_HIGH, 32'h0000_0a00, 4'hf, q);
    bus(1'b1, OFS_CELL_CFG, 32'h0001_3fff, 4'hf, q);
    foreach (rows[i]) begin
      scan(rows[i], 1'b0);
      @(negedge ref_clk);
      if (rows[i].cfg == 3'h0)
        chk("override", 32'(rows[i].x), 32'({path_override.adc_in_short,
            path_override.amp_in_short, path_override.level_shift_amp_short,
            path_override.therm_ref}));
      else
        chk("alt mux", 32'h1, 32'(path_override.alternate_mux_path));
      if (rows[i].cfg == SCF_SHORT) begin
        chk("switch en", 32'h0, 32'(balance_switch_enable));
        chk("measure en", 32'h3ffe, 32'(channel_measure_enable));
      end
      wait_done();
      if (rows[i].cfg == 3'h0) begin
        bus(1'b0, OFS_DIAG_RESULT_A, 32'h0, 4'hf, q);
        chk("result a", {16'h0, rows[i].d, 2'h0}, q);
        bus(1'b0, OFS_PASS, 32'h0, 4'hf, q);
        chk("pass a", 32'(rows[i].ok), 32'(q[0]));
      end else begin
        bus(1'b0, OFS_ALERT, 32'h0, 4'hf, q);
        chk("vector", 32'(rows[i].x), 32'(q[13:0]));
        chk("summary", 32'(|rows[i].x), 32'(q[AL_SUM]));
        chk("cell alerts", 32'h5, 32'(q[20:18]));
      end
    end
    // Lane two write of zero clears only the summary
    bus(1'b1, OFS_ALERT, 32'h0, 4'h4, q);
    bus(1'b0, OFS_ALERT, 32'h0, 4'hf, q);
    chk("summary clear", 32'h0, 32'(q[AL_SUM]));
    chk("vector hold", 32'h0802, 32'(q[13:0]));
    // A slow engine lets the cleared vector be seen mid-scan
    gap = 8'h3c;
    scan(rows[23], 1'b0);
    bus(1'b0, OFS_ALERT, 32'h0, 4'hf, q);
    chk("vector cleared", 32'h0, 32'(q[13:0]));
    wait_done();
    bus(1'b0, OFS_ALERT, 32'h0, 4'hf, q);
    chk("vector again", 32'h1_0802, 32'(q[16:0]));
    gap = 8'h01;
    scan('{4'h6,3'h0,1'h0,4'hd,14'h2000,1'h1,14'h8}, 1'b1);
    wait_done();
    bus(1'b0, OFS_DIAG_RESULT_B, 32'h0, 4'hf, q);
    chk("result b", 32'h8000, q);
    bus(1'b0, OFS_PASS, 32'h0, 4'hf, q);
    chk("pass b", 32'h1, 32'(q[1]));
    conclude();
  end
endmodule

bind adg_diag adg_diag_sva u_adg_diag_sva (.*);
